//--- design/drpd_ctrl.sv
/*
  rank power-down controller: open-page request reordering, data scrambling,
  lane remap options, unpopulated rank tri-state and per-rank cke power-down.
  assumes one 100 mhz clock, requests from logic on the same clock and a
  command sink that accepts one issued request per cycle while ready is high.
*/
`timescale 1ns/1ps
`default_nettype none
`include "drpd_map.svh"

// Behaviour
// - pending hits to an open page issue first, back to back
// - write data scrambled, read data descrambled with a running pattern
// - ddr5 byte lanes may swap inside pairs 0-1 and 2-3
// - lpddr5 ca and cs order reversible per x16 sub-channel
// - lpddr4x ca order mirrorable per x16 sub-channel
// - unpopulated rank stops driving clock, odt and cs; cke only once its tri-state bit is set
// - all ranks populated after reset; tri-state only once software enables it
// - four cke outputs, one per rank
// - config bits 15:12 select the sleep type
// - config bits 11:0 hold the idle threshold in command clocks
// - one idle counter per rank, restarted on each arriving request
// - idle time restarts on request arrival and counts only while nothing is queued for the rank
// - cke drops once the threshold is reached and nothing is queued
// - open-page sleep keeps pages open, waits txp on exit
// - closed-bank sleep precharges first, pages closed after wake, waits txp
// - reset type is open-page sleep on low-power variants, else none
// - config writable at run time unless register lock is set
// - ranks wake for refresh and return to sleep afterwards
// - cke stays low after reset until software releases it
module drpd_ctrl import drpd_pkg::*; #(
  parameter bit LOW_POWER_VARIANT = 1'b1
) (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic [`DRPD_ADDR_W-1:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out,
  input wire logic req_valid_in,
  input wire drpd_req_t req_in,
  output logic req_ready_out,
  output logic issue_valid_out,
  output drpd_req_t issue_out,
  input wire logic issue_ready_in,
  input wire logic refresh_req_in,
  output logic refresh_go_out,
  input wire logic [31:0] wr_data_in,
  output logic [31:0] dq_out,
  input wire logic [31:0] dq_in,
  output logic [31:0] rd_data_out,
  input wire logic [7:0] ca_in,
  output logic [7:0] ca_out,
  output logic [3:0] cke_out,
  output logic [3:0] cke_oe_out,
  output logic [3:0] ctl_oe_out
);
  localparam logic [3:0] RESET_TYPE = LOW_POWER_VARIANT ? `DRPD_TYPE_OPEN : `DRPD_TYPE_NONE;

  drpd_cfg_t cfg;
  logic [3:0] unpopulated;
  logic [3:0] tristate_en;
  logic [7:0] lane_cfg;
  logic lock;
  logic released;
  drpd_req_t queue [`DRPD_QDEPTH];
  logic [`DRPD_QDEPTH-1:0] q_valid;
  logic [3:0] page_open;
  logic [7:0] open_row [`DRPD_RANKS];
  logic [11:0] idle_cnt [`DRPD_RANKS];
  drpd_state_t pd_state [`DRPD_RANKS];
  logic [3:0] rank_busy;
  logic [3:0] rank_awake;
  logic [1:0] pick;
  logic pick_ok;
  logic [1:0] free_slot;
  logic free_ok;
  logic [15:0] lfsr;
  logic [3:0] sleep_type;
  logic [3:0] wake_all;

  // unknown sleep codes fold to none
  always_comb begin
    sleep_type = cfg.sleep_type_field;
    if (sleep_type != `DRPD_TYPE_OPEN && sleep_type != `DRPD_TYPE_CLOSED) begin
      sleep_type = `DRPD_TYPE_NONE;
    end
  end

  // register writes; lock freezes all configuration
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cfg <= {RESET_TYPE, `DRPD_THR_RESET};
      unpopulated <= 4'h0;
      tristate_en <= 4'h0;
      lane_cfg <= 8'h00;
      lock <= 1'b0;
      released <= 1'b0;
    end else if (wr_in && !lock) begin
      unique case (addr_in)
        `DRPD_OFF_PDCFG: begin
          cfg <= wdata_in;
          released <= 1'b1;
        end
        `DRPD_OFF_RANKCFG: begin
          unpopulated <= wdata_in[3:0];
          tristate_en <= wdata_in[7:4];
        end
        `DRPD_OFF_LANECFG: lane_cfg <= wdata_in[7:0];
        `DRPD_OFF_CTRL: lock <= wdata_in[0];
        default: begin
        end
      endcase
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_out <= 16'h0000;
    end else if (rd_in) begin
      unique case (addr_in)
        `DRPD_OFF_PDCFG: rdata_out <= cfg;
        `DRPD_OFF_RANKCFG: rdata_out <= {8'h00, tristate_en, unpopulated};
        `DRPD_OFF_LANECFG: rdata_out <= {8'h00, lane_cfg};
        `DRPD_OFF_CTRL: rdata_out <= {15'h0000, lock};
        `DRPD_OFF_STATUS: rdata_out <= {4'h0, page_open, rank_awake, cke_out};
        default: rdata_out <= 16'h0000;
      endcase
    end else begin
      rdata_out <= 16'h0000;
    end
  end

  // pick an open-page hit for an awake rank before any other entry
  always_comb begin
    pick = 2'd0;
    pick_ok = 1'b0;
    free_slot = 2'd0;
    free_ok = 1'b0;
    for (int i = `DRPD_QDEPTH - 1; i >= 0; i--) begin
      if (q_valid[i] && rank_awake[queue[i].rank] && !pick_ok) begin
        pick = 2'(i);
        pick_ok = 1'b1;
      end
      if (!q_valid[i]) begin
        free_slot = 2'(i);
        free_ok = 1'b1;
      end
    end
    for (int i = `DRPD_QDEPTH - 1; i >= 0; i--) begin
      if (q_valid[i] && rank_awake[queue[i].rank] && page_open[queue[i].rank]
          && open_row[queue[i].rank] == queue[i].row) begin
        pick = 2'(i);
        pick_ok = 1'b1;
      end
    end
  end

  assign req_ready_out = free_ok;
  assign issue_valid_out = pick_ok;
  assign issue_out = queue[pick];
  assign refresh_go_out = refresh_req_in && (&rank_awake);

  // pending request store
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      q_valid <= '0;
      for (int i = 0; i < `DRPD_QDEPTH; i++) begin
        queue[i] <= '0;
      end
    end else begin
      if (pick_ok && issue_ready_in) begin
        q_valid[pick] <= 1'b0;
      end
      if (req_valid_in && free_ok) begin
        q_valid[free_slot] <= 1'b1;
        queue[free_slot] <= req_in;
      end
    end
  end

  // per-rank idle counter, page tracking and sleep state
  genvar r;
  generate
    for (r = 0; r < `DRPD_RANKS; r++) begin : g_rank
      logic arrive;
      logic queued;
      logic expired;
      logic [3:0] txp_cnt;
      always_comb begin
        queued = 1'b0;
        for (int i = 0; i < `DRPD_QDEPTH; i++) begin
          if (q_valid[i] && queue[i].rank == 2'(r)) begin
            queued = 1'b1;
          end
        end
      end
      assign arrive = req_valid_in && free_ok && req_in.rank == 2'(r);
      assign rank_busy[r] = queued || arrive;
      assign expired = idle_cnt[r] >= cfg.idle_threshold_field;
      assign rank_awake[r] = pd_state[r] == drpd_awake;
      assign wake_all[r] = refresh_req_in;

      // idle count restarts on arrival and holds while the rank has a queued entry
      always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          idle_cnt[r] <= 12'h000;
        end else if (arrive) begin
          idle_cnt[r] <= 12'h000;
        end else if (!queued && !expired) begin
          idle_cnt[r] <= idle_cnt[r] + 12'h001;
        end
      end

      // open page tracking: issued rows open, closed-bank sleep closes all
      always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          page_open[r] <= 1'b0;
          open_row[r] <= 8'h00;
        end else if (pd_state[r] == drpd_closing) begin
          page_open[r] <= 1'b0;
        end else if (pick_ok && issue_ready_in && issue_out.rank == 2'(r)) begin
          page_open[r] <= 1'b1;
          open_row[r] <= issue_out.row;
        end
      end

      // sleep sequence with txp wait on wake
      always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          pd_state[r] <= drpd_awake;
          txp_cnt <= 4'h0;
        end else begin
          unique case (pd_state[r])
            drpd_awake: begin
              if (expired && !rank_busy[r] && !wake_all[r] && released
                  && sleep_type == `DRPD_TYPE_OPEN) begin
                pd_state[r] <= drpd_asleep;
              end else if (expired && !rank_busy[r] && !wake_all[r] && released
                  && sleep_type == `DRPD_TYPE_CLOSED) begin
                pd_state[r] <= drpd_closing;
              end
            end
            drpd_closing: pd_state[r] <= drpd_asleep;
            drpd_asleep: begin
              if (rank_busy[r] || wake_all[r] || sleep_type == `DRPD_TYPE_NONE) begin
                pd_state[r] <= drpd_waking;
                txp_cnt <= 4'(`DRPD_TXP_CYC);
              end
            end
            drpd_waking: begin
              if (txp_cnt <= 4'h1) begin
                pd_state[r] <= drpd_awake;
              end
              txp_cnt <= txp_cnt - 4'h1;
            end
          endcase
        end
      end

      // cke low until released, low while asleep; ctl drive off for empty ranks, cke drive off only once tri-state is set
      always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          cke_out[r] <= 1'b0;
          cke_oe_out[r] <= 1'b1;
          ctl_oe_out[r] <= 1'b1;
        end else begin
          cke_out[r] <= released && pd_state[r] != drpd_asleep;
          cke_oe_out[r] <= !(unpopulated[r] && tristate_en[r]);
          ctl_oe_out[r] <= !unpopulated[r];
        end
      end
    end
  endgenerate

  // scrambler pattern advances once per data beat
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      lfsr <= `DRPD_SCR_SEED;
    end else begin
      lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    end
  end

  // byte pair swap and scramble on write, inverse on read
  logic [31:0] wr_swapped;
  logic [31:0] rd_unscr;
  always_comb begin
    wr_swapped = wr_data_in;
    rd_unscr = dq_in ^ {lfsr, lfsr};
    if (lane_cfg[0]) begin
      wr_swapped = {wr_data_in[23:16], wr_data_in[31:24], wr_data_in[7:0], wr_data_in[15:8]};
      rd_unscr = {rd_unscr[23:16], rd_unscr[31:24], rd_unscr[7:0], rd_unscr[15:8]};
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      dq_out <= 32'h00000000;
      rd_data_out <= 32'h00000000;
    end else begin
      dq_out <= wr_swapped ^ {lfsr, lfsr};
      rd_data_out <= rd_unscr;
    end
  end

  // ca order reversal per sub-channel nibble: bits 1 and 3 lpddr5 ca/cs, bits 2 and 4 lpddr4x mirror
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ca_out <= 8'h00;
    end else begin
      for (int s = 0; s < 2; s++) begin
        for (int b = 0; b < 4; b++) begin
          ca_out[s*4+b] <= (lane_cfg[1+s*2] || lane_cfg[2+s*2]) ? ca_in[s*4+3-b] : ca_in[s*4+b];
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- design/drpd_map.svh
/*
  register offsets, field positions, reset values and timing counts of the
  rank power-down controller. assumes inclusion by bare name.
*/
`ifndef DRPD_MAP_SVH
`define DRPD_MAP_SVH

`define DRPD_ADDR_W 4
`define DRPD_OFF_PDCFG 4'h0
`define DRPD_OFF_RANKCFG 4'h1
`define DRPD_OFF_LANECFG 4'h2
`define DRPD_OFF_CTRL 4'h3
`define DRPD_OFF_STATUS 4'h4
`define DRPD_TYPE_HI 15
`define DRPD_TYPE_LO 12
`define DRPD_THR_HI 11
`define DRPD_THR_LO 0
`define DRPD_TYPE_NONE 4'h0
`define DRPD_TYPE_OPEN 4'h1
`define DRPD_TYPE_CLOSED 4'h2
`define DRPD_THR_RESET 12'h040
`define DRPD_CLK_MHZ 100
`define DRPD_TXP_NS 8
`define DRPD_TXP_CYC ((`DRPD_TXP_NS * `DRPD_CLK_MHZ + 999) / 1000)
`define DRPD_RANKS 4
`define DRPD_QDEPTH 4
`define DRPD_ROW_W 8
`define DRPD_SCR_SEED 16'hace1

`endif

//--- design/drpd_pkg.sv
/*
  types of the rank power-down controller.
  assumes drpd_map.svh is on the include path.
*/
package drpd_pkg;
  typedef enum logic [1:0] {drpd_awake, drpd_closing, drpd_asleep, drpd_waking} drpd_state_t;
  typedef struct packed {
    logic [1:0] rank;
    logic [7:0] row;
    logic write;
  } drpd_req_t;
  typedef struct packed {
    logic [3:0] sleep_type_field;
    logic [11:0] idle_threshold_field;
  } drpd_cfg_t;
endpackage

//--- tb/drpd_ctrl_props.sv
/*
  port-level properties of the rank power-down controller.
  assumes it is bound to drpd_ctrl built with the low-power variant.
*/
`timescale 1ns/1ps
`default_nettype none
`include "drpd_map.svh"
module drpd_ctrl_props import drpd_pkg::*; (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic [3:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [15:0] rdata_out,
  input wire logic req_valid_in,
  input wire logic req_ready_out,
  input wire logic issue_valid_out,
  input wire drpd_req_t issue_out,
  input wire logic issue_ready_in,
  input wire logic refresh_req_in,
  input wire logic refresh_go_out,
  input wire logic [3:0] cke_out,
  input wire logic [3:0] cke_oe_out,
  input wire logic [3:0] ctl_oe_out
);
  logic lock, seen;
  logic [7:0] rk;
  logic [3:0] ty;
  logic [2:0] occ;
  // shadow of lock, rank setup, sleep type and release
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      lock <= 1'h0;
      seen <= 1'h0;
      rk <= 8'h00;
      ty <= 4'h1;
    end else if (wr_in && !lock) begin
      if (addr_in == `DRPD_OFF_CTRL) lock <= wdata_in[0];
      if (addr_in == `DRPD_OFF_PDCFG) seen <= 1'h1;
      if (addr_in == `DRPD_OFF_PDCFG) ty <= wdata_in[15:12];
      if (addr_in == `DRPD_OFF_RANKCFG) rk <= wdata_in[7:0];
    end
  end
  // queue occupancy from the two handshakes
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) occ <= 3'h0;
    else occ <= occ + 3'(req_valid_in && req_ready_out) - 3'(issue_valid_out && issue_ready_in);
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  chk_cke_reset_low: assert property ($rose(nrst_in) |-> cke_out == 4'h0) else $error("cke high at reset exit");
  chk_cke_needs_cfg: assert property (cke_out != 4'h0 |-> seen) else $error("cke high before release");
  chk_read_quiet: assert property (!$past(rd_in) |-> rdata_out == 16'h0) else $error("read data without read");
  chk_ctl_drive: assert property ($stable(rk) [*3] |-> ctl_oe_out == ~rk[3:0]) else $error("ctl enable wrong");
  chk_cke_drive: assert property ($stable(rk) [*3] |-> cke_oe_out == ~(rk[3:0] & rk[7:4])) else $error("cke enable wrong");
  chk_refresh_gate: assert property (refresh_go_out |-> refresh_req_in) else $error("refresh without request");
  chk_issue_awake: assert property (issue_valid_out |-> cke_out[issue_out.rank]) else $error("issue to sleeping rank");
  chk_queue_ready: assert property (req_ready_out == (occ != 3'h4)) else $error("ready disagrees with fill");
  chk_sleep_type: assert property ($fell(cke_out[0]) |-> ty == 4'h1 || ty == 4'h2) else $error("sleep with type none");
endmodule
bind drpd_ctrl drpd_ctrl_props chk_u (.ref_clk_in, .nrst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
  .req_valid_in, .req_ready_out, .issue_valid_out, .issue_out, .issue_ready_in, .refresh_req_in, .refresh_go_out,
  .cke_out, .cke_oe_out, .ctl_oe_out);
`default_nettype wire

//--- tb/drpd_dram_model.sv
/*
  far-side dram model: takes issued commands and returns data lines.
  assumes the controller's clock and reset.
*/
`timescale 1ns/1ps
`default_nettype none
module drpd_dram_model (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic hold_in,
  input wire logic slow_in,
  input wire logic issue_valid_in,
  input wire logic [31:0] dq_from_ctrl_in,
  output logic ready_out,
  output logic [31:0] dq_out
);
  // prompt, every other cycle when slow, never while held
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) ready_out <= 1'h0;
    else ready_out <= !hold_in && !(slow_in && ready_out);
  end
  // data captured on accept, else an ever-changing inverse
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) dq_out <= 32'h0;
    else dq_out <= (issue_valid_in && ready_out) ? dq_from_ctrl_in : ~dq_out;
  end
endmodule
`default_nettype wire

//--- tb/test_drpd_ctrl.sv
/*
  self-checking bench of the rank power-down controller.
  assumes drpd_ctrl, its checker and the dram model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "drpd_map.svh"
module test_drpd_ctrl import drpd_pkg::*; ;
  typedef struct {logic [15:0] cfg; logic [7:0] ca; logic [15:0] dqx;} drpd_row_t;
  drpd_row_t rows [6] = '{'{16'h0, 8'h31, 16'h00ff}, '{16'h1, 8'h31, 16'hff00}, '{16'h2, 8'h38, 16'h00ff},
    '{16'h4, 8'h38, 16'h00ff}, '{16'h8, 8'hc1, 16'h00ff}, '{16'h10, 8'hc1, 16'h00ff}};
  logic ref_clk_in, nrst_in, wr_in, rd_in, req_valid_in, refresh_req_in, hold, slow;
  logic req_ready_out, issue_valid_out, issue_ready_in, refresh_go_out;
  logic [3:0] addr_in, cke_out, cke_oe_out, ctl_oe_out;
  logic [15:0] wdata_in, rdata_out, v, x;
  logic [31:0] wr_data_in, dq_out, dq_in, rd_data_out, a;
  logic [7:0] ca_in, ca_out;
  logic [7:0] got [$];
  drpd_req_t req_in, issue_out;
  int err_total, n_tests;
  drpd_ctrl dut_u (.ref_clk_in, .nrst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .req_valid_in, .req_in,
    .req_ready_out, .issue_valid_out, .issue_out, .issue_ready_in, .refresh_req_in, .refresh_go_out, .wr_data_in,
    .dq_out, .dq_in, .rd_data_out, .ca_in, .ca_out, .cke_out, .cke_oe_out, .ctl_oe_out);
  drpd_dram_model far_u (.ref_clk_in, .nrst_in, .hold_in(hold), .slow_in(slow), .issue_valid_in(issue_valid_out),
    .dq_from_ctrl_in(dq_out), .ready_out(issue_ready_in), .dq_out(dq_in));
  // clock
  initial begin
    ref_clk_in = 1'h0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  // record issued rows
  always @(posedge ref_clk_in) if (issue_valid_out === 1'h1 && issue_ready_in === 1'h1) got.push_back(issue_out.row);
  task automatic conclude();
    if (err_total == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask
  task automatic wr(input logic [3:0] ad, input logic [15:0] d);
    @(posedge ref_clk_in);
    addr_in <= ad;
    wdata_in <= d;
    wr_in <= 1'h1;
    @(posedge ref_clk_in);
    wr_in <= 1'h0;
  endtask
  task automatic rdchk(input logic [3:0] ad, input logic [15:0] e);
    @(posedge ref_clk_in);
    addr_in <= ad;
    rd_in <= 1'h1;
    @(posedge ref_clk_in);
    rd_in <= 1'h0;
    #1 v = rdata_out;
    chk(v, e);
  endtask
  task automatic send(input logic [1:0] rk, input logic [7:0] row);
    @(posedge ref_clk_in);
    req_in <= '{rank: rk, row: row, write: 1'h0};
    req_valid_in <= 1'h1;
    do @(negedge ref_clk_in); while (req_ready_out !== 1'h1);
    @(posedge ref_clk_in);
    req_valid_in <= 1'h0;
  endtask
  // watchdog
  initial begin
    #200000;
    err_total++;
    conclude();
  end
  // main sequence
  initial begin
    {nrst_in, wr_in, rd_in, req_valid_in, refresh_req_in, hold, slow} = 7'h0;
    {addr_in, wdata_in, req_in} = '0;
    wr_data_in = 32'hff;
    ca_in = 8'h31;
    err_total = 0;
    n_tests = 0;
    repeat (20) @(posedge ref_clk_in);
    nrst_in <= 1'h1;
    tick(1);
    chk(cke_out, 4'h0);
    chk(cke_oe_out, 4'hf);
    rdchk(`DRPD_OFF_PDCFG, 16'h1040);
    rdchk(4'h7, 16'h0);
    foreach (rows[i]) begin
      wr(`DRPD_OFF_LANECFG, rows[i].cfg);
      tick(3);
      chk(ca_out, rows[i].ca);
      chk(dq_out[15:0] ^ dq_out[31:16], rows[i].dqx);
      x = dq_in[15:0] ^ dq_in[31:16];
      chk(rd_data_out[15:0] ^ rd_data_out[31:16], rows[i].cfg[0] ? {x[7:0], x[15:8]} : x);
      rdchk(`DRPD_OFF_LANECFG, rows[i].cfg);
    end
    a = dq_out;
    tick(1);
    chk(dq_out != a, 1'h1);
    wr(`DRPD_OFF_PDCFG, 16'h0040);
    tick(5);
    chk(cke_out, 4'hf);
    wr(`DRPD_OFF_PDCFG, 16'h1040);
    // idle count since reset must reach the 0x040 threshold first
    tick(20);
    chk(cke_out, 4'h0);
    send(2'h0, 8'h05);
    tick(50);
    chk(cke_out, 4'h1);
    tick(30);
    chk(cke_out, 4'h0);
    @(posedge ref_clk_in);
    refresh_req_in <= 1'h1;
    tick(4);
    chk({refresh_go_out, cke_out}, 5'h1f);
    @(posedge ref_clk_in);
    refresh_req_in <= 1'h0;
    tick(5);
    chk(cke_out, 4'h0);
    wr(`DRPD_OFF_PDCFG, 16'h0040);
    hold <= 1'h1;
    tick(3);
    got.delete();
    send(2'h0, 8'h07);
    send(2'h0, 8'h05);
    send(2'h0, 8'h05);
    send(2'h1, 8'h09);
    tick(1);
    chk(req_ready_out, 1'h0);
    hold <= 1'h0;
    slow <= 1'h1;
    tick(16);
    // hits first, then the highest-index awake entry
    chk({got[0], got[1], got[2], got[3]}, 32'h05050907);
    wr(`DRPD_OFF_PDCFG, 16'h2004);
    tick(20);
    rdchk(`DRPD_OFF_STATUS, 16'h0);
    chk(v & 16'h0f0f, 16'h0);
    wr(`DRPD_OFF_PDCFG, 16'h3004);
    tick(5);
    chk(cke_out, 4'hf);
    wr(`DRPD_OFF_RANKCFG, 16'h0008);
    tick(3);
    chk({ctl_oe_out, cke_oe_out}, 8'h7f);
    wr(`DRPD_OFF_RANKCFG, 16'h0088);
    tick(3);
    chk(cke_oe_out, 4'h7);
    wr(`DRPD_OFF_CTRL, 16'h0001);
    wr(`DRPD_OFF_PDCFG, 16'h1111);
    rdchk(`DRPD_OFF_PDCFG, 16'h3004);
    conclude();
  end
endmodule
`default_nettype wire
